// ### pkg/channel_sequencer_map.svh
// offsets, field positions, reset values and descriptor layout for the channel sequencer
`ifndef CHANNEL_SEQUENCER_MAP_SVH
`define CHANNEL_SEQUENCER_MAP_SVH

// apb register byte offsets
`define SEQ_CTRL_OFS        8'h00
`define SEQ_HEAD_BASE_OFS   8'h04
`define SEQ_SLOT_BASE_OFS   8'h08
`define SEQ_INTQ_BASE_OFS   8'h0c
`define SEQ_SREQ_OFS        8'h10
`define SEQ_STATUS_OFS      8'h14

// control register fields
`define CTRL_TX_INH_BIT     0
`define CTRL_RX_INH_BIT     1
`define CTRL_TRISTATE_BIT   2
`define CTRL_EOM_MASK_BIT   3
`define CTRL_RESET          4'h0
`define BASE_RESET          32'h0000_0000

// service request and status register fields
`define SREQ_DIR_BIT        8
`define STATUS_PEND_LSB     8
`define STATUS_ACK_LSB      16

// descriptor layout in shared memory
`define BD_OWNER_BIT        31
`define BD_POLL_OFF_BIT     30
`define BD_LEN_MSB          15
`define MD_BUFPTR_OFS       32'h0000_0004
`define MD_NEXT_OFS         32'h0000_0008
`define DIR_SLOT_STRIDE     32'h0000_0004
`define WORD_BYTES          32'h0000_0004
`define WORD_BITS           5'h1f

`endif

// ### pkg/channel_sequencer_pkg.sv
// types shared by the channel descriptor sequencer
`default_nettype none
package channel_sequencer_pkg;

    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_head = 4'h1,
        st_ack  = 4'h2,
        st_bd   = 4'h3,
        st_poll = 4'h4,
        st_ptr  = 4'h5,
        st_nxt  = 4'h6,
        st_slot = 4'h7,
        st_data = 4'h8,
        st_stat = 4'h9,
        st_intr = 4'ha
    } seq_state_e;

    typedef enum logic [1:0] {
        op_none       = 2'h0,
        op_activate   = 2'h1,
        op_jump       = 2'h2,
        op_deactivate = 2'h3
    } svc_op_e;

endpackage
`default_nettype wire

// ### src/channel_descriptor_sequencer.sv
// one channel's transmit and receive descriptor sequencers with apb registers and memory master port
`include "channel_sequencer_map.svh"
`default_nettype none

// Behaviour
// - tx inhibit 0: slot gets bd address; after message read next, overwrite bd
// - tx inhibit 1: prefetch next pointer into slot; jump there without overwrite
// - tx message: fetch words from memory while serial port shifts them out
// - end of message writes interrupt unless masked, status unless inhibited
// - after a message read the next descriptor and recheck ownership, forever
// - rx activate reads head pointer, then the descriptor it addresses
// - rx owner bit 0: device owns; load buffer pointer and length
// - rx owner bit 1: poll descriptor until owned or new request
// - rx inhibit 0: slot gets bd address; after message read next, overwrite bd
// - rx inhibit 1: no overwrite; slot gets next pointer, jump after message
// - rx samples serial data while writing words to memory
// - tx and rx run independent machines, each request acknowledged alone
// - tx activate reads head pointer, then the descriptor it addresses
// - tx owner bit 1: device owns and loads buffer; 0: poll
// - tx suspended: data pin tristated or held at 1 per select bit
module channel_descriptor_sequencer
    import channel_sequencer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        tx_serial_clock,
    input  wire logic        tx_frame_sync,
    output logic             tx_serial_out,
    output logic             tx_serial_oe,
    input  wire logic        rx_serial_clock,
    input  wire logic        rx_frame_sync,
    input  wire logic        rx_serial_in,
    input  wire logic        rx_out_of_frame
);

    logic [3:0]  ctrl;
    logic [31:0] head_base;
    logic [31:0] slot_base;
    logic [31:0] intq_base;
    logic [3:0]  intq_idx;

    seq_state_e  st       [2];
    svc_op_e     pop      [2];
    logic        pend     [2];
    logic        fresh    [2];
    logic        jump_pend[2];
    logic        post     [2];
    logic        done_ack [2];
    logic [31:0] bd       [2];
    logic [31:0] msg_addr [2];
    logic [31:0] bufp     [2];
    logic [31:0] nxt      [2];
    logic [14:0] words    [2];

    logic        want     [2];
    logic        wwe      [2];
    logic [31:0] waddr    [2];
    logic [31:0] wdat     [2];
    logic        done     [2];
    logic        inflight [2];
    logic        restart  [2];
    logic        data_done[2];
    logic        is_intr  [2];
    logic        sreq_hit [2];
    logic        ack_clr  [2];

    logic        owner;
    logic        tx_full;
    logic        rx_full;
    logic [31:0] tx_shift;
    logic [31:0] rx_shift;
    logic [4:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic        tx_clk_q;
    logic        rx_clk_q;
    logic        tx_synced;
    logic        rx_synced;

    // apb decode
    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign setup  = psel & ~penable;
    assign wr_en  = psel & penable & pwrite & pready;
    assign mapped = (paddr == `SEQ_CTRL_OFS) | (paddr == `SEQ_HEAD_BASE_OFS) | (paddr == `SEQ_SLOT_BASE_OFS)
                  | (paddr == `SEQ_INTQ_BASE_OFS) | (paddr == `SEQ_SREQ_OFS) | (paddr == `SEQ_STATUS_OFS);
    assign status_word = {14'h0, done_ack[1], done_ack[0], 6'h0, pend[1], pend[0], st[1], st[0]};
    assign rd_mux = (paddr == `SEQ_CTRL_OFS)      ? {28'h0, ctrl} :
                    (paddr == `SEQ_HEAD_BASE_OFS) ? head_base :
                    (paddr == `SEQ_SLOT_BASE_OFS) ? slot_base :
                    (paddr == `SEQ_INTQ_BASE_OFS) ? intq_base :
                    (paddr == `SEQ_SREQ_OFS)      ? {22'h0, pend[1], pend[0], 6'h0, pop[1] | pop[0]} :
                    (paddr == `SEQ_STATUS_OFS)    ? status_word : 32'h0;

    // answer registered in setup, so every access completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= `CTRL_RESET;
            head_base <= `BASE_RESET;
            slot_base <= `BASE_RESET;
            intq_base <= `BASE_RESET;
        end else if (wr_en) begin
            if (paddr == `SEQ_CTRL_OFS)      ctrl      <= pwdata[3:0];
            if (paddr == `SEQ_HEAD_BASE_OFS) head_base <= pwdata;
            if (paddr == `SEQ_SLOT_BASE_OFS) slot_base <= pwdata;
            if (paddr == `SEQ_INTQ_BASE_OFS) intq_base <= pwdata;
        end
    end

    // memory master: alternate priority so a polling direction cannot starve the other
    logic pick;
    logic any_want;
    assign any_want = want[0] | want[1];
    assign pick     = want[~owner] ? ~owner : owner;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0;
            mem_wdata <= 32'h0;
            owner     <= 1'b0;
        end else if (mem_req) begin
            if (mem_ack) mem_req <= 1'b0;
        end else if (any_want) begin
            mem_req   <= 1'b1;
            owner     <= pick;
            mem_we    <= wwe[pick];
            mem_addr  <= waddr[pick];
            mem_wdata <= wdat[pick];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) intq_idx <= 4'h0;
        else if (done[owner] && is_intr[owner]) intq_idx <= intq_idx + 4'h1;
    end

    for (genvar d = 0; d < 2; d++) begin : g_dir
        logic        inh;
        logic        masked;
        logic        own_rd;
        logic        take;
        logic        finished;
        logic [31:0] intq_addr;
        logic [31:0] base_ofs;

        assign inh       = ctrl[`CTRL_TX_INH_BIT + d];
        assign masked    = ctrl[`CTRL_EOM_MASK_BIT];
        assign own_rd    = (mem_rdata[`BD_OWNER_BIT] == (d == 0));
        assign take      = fresh[d] & ~inflight[d];
        assign inflight[d]  = mem_req & (owner == d);
        assign done[d]      = inflight[d] & mem_ack;
        assign data_done[d] = done[d] & (st[d] == st_data);
        assign is_intr[d]   = (st[d] == st_ack) | (st[d] == st_intr);
        // tx jump waits for the running message but not for a poll; the rest restarts
        assign restart[d]   = take & ~((d == 0) && (pop[d] == op_jump) && !(st[d] inside {st_idle, st_bd, st_poll}));
        assign finished     = (words[d] == 15'h0) & ((d == 1) | ~tx_full);
        assign intq_addr    = intq_base + {26'h0, intq_idx, 2'h0};
        assign base_ofs     = (d == 0) ? 32'h0 : `DIR_SLOT_STRIDE;
        assign sreq_hit[d]  = wr_en & (paddr == `SEQ_SREQ_OFS) & (pwdata[`SREQ_DIR_BIT] == d)
                            & (pwdata[1:0] != op_none);
        assign ack_clr[d]   = wr_en & (paddr == `SEQ_STATUS_OFS) & pwdata[`STATUS_ACK_LSB + d];

        always_comb begin
            want[d]  = ~fresh[d];
            wwe[d]   = 1'b0;
            waddr[d] = msg_addr[d];
            wdat[d]  = 32'h0;
            case (st[d])
                st_head: waddr[d] = head_base + base_ofs;
                st_ack: begin
                    wwe[d]   = 1'b1;
                    waddr[d] = intq_addr;
                    wdat[d]  = {1'b1, 1'b0, 21'h0, d[0], 6'h0, pop[d]};
                end
                st_bd:   waddr[d] = msg_addr[d];
                st_ptr:  waddr[d] = msg_addr[d] + `MD_BUFPTR_OFS;
                st_nxt:  waddr[d] = msg_addr[d] + `MD_NEXT_OFS;
                st_slot: begin
                    wwe[d]   = 1'b1;
                    waddr[d] = slot_base + base_ofs;
                    wdat[d]  = inh ? nxt[d] : msg_addr[d];
                end
                st_data: begin
                    wwe[d]   = (d == 1);
                    waddr[d] = bufp[d];
                    wdat[d]  = rx_shift;
                    want[d]  = ~fresh[d] & (words[d] != 15'h0)
                             & ((d == 0) ? ~tx_full : rx_full);
                end
                st_stat: begin
                    wwe[d]   = 1'b1;
                    wdat[d]  = {~bd[d][`BD_OWNER_BIT], bd[d][30:0]};
                end
                st_intr: begin
                    wwe[d]   = 1'b1;
                    waddr[d] = intq_addr;
                    wdat[d]  = {1'b0, 1'b1, 21'h0, d[0], 8'h0};
                end
                default: want[d] = 1'b0;
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st[d]        <= st_idle;
                pop[d]       <= op_none;
                pend[d]      <= 1'b0;
                fresh[d]     <= 1'b0;
                jump_pend[d] <= 1'b0;
                post[d]      <= 1'b0;
                bd[d]        <= 32'h0;
                msg_addr[d]  <= 32'h0;
                bufp[d]      <= 32'h0;
                nxt[d]       <= 32'h0;
                words[d]     <= 15'h0;
            end else begin
                if (sreq_hit[d] && !pend[d]) begin
                    pend[d]  <= 1'b1;
                    fresh[d] <= 1'b1;
                    pop[d]   <= svc_op_e'(pwdata[1:0]);
                end
                if (take) begin
                    fresh[d] <= 1'b0;
                    if (!restart[d]) jump_pend[d] <= 1'b1;
                    else if (pop[d] == op_deactivate) begin
                        st[d]        <= st_ack;
                        jump_pend[d] <= 1'b0;
                        words[d]     <= 15'h0;
                    end else begin
                        st[d]        <= st_head;
                        jump_pend[d] <= 1'b0;
                    end
                end else if (st[d] == st_data && finished) begin
                    post[d] <= 1'b1;
                    st[d]   <= !inh ? st_nxt : (masked ? (jump_pend[d] ? st_head : st_bd) : st_intr);
                    if (inh && masked) begin
                        msg_addr[d]  <= nxt[d];
                        jump_pend[d] <= 1'b0;
                    end
                end else if (done[d]) begin
                    case (st[d])
                        st_head: begin
                            msg_addr[d] <= mem_rdata;
                            st[d]       <= st_ack;
                        end
                        st_ack: begin
                            pend[d] <= 1'b0;
                            st[d]   <= (pop[d] == op_deactivate) ? st_idle : st_bd;
                        end
                        st_bd: begin
                            bd[d] <= mem_rdata;
                            // owned: go on; not owned: poll again unless polling is off
                            st[d] <= own_rd ? st_ptr :
                                     (mem_rdata[`BD_POLL_OFF_BIT] ? st_poll : st_bd);
                        end
                        st_ptr: begin
                            bufp[d]  <= mem_rdata;
                            words[d] <= 15'((bd[d][`BD_LEN_MSB:0] + 16'h3) >> 2);
                            post[d]  <= 1'b0;
                            st[d]    <= inh ? st_nxt : st_slot;
                        end
                        st_nxt: begin
                            nxt[d] <= mem_rdata;
                            st[d]  <= post[d] ? st_stat : st_slot;
                        end
                        st_slot: st[d] <= st_data;
                        st_data: begin
                            bufp[d]  <= bufp[d] + `WORD_BYTES;
                            words[d] <= words[d] - 15'h1;
                        end
                        st_stat: begin
                            st[d] <= masked ? (jump_pend[d] ? st_head : st_bd) : st_intr;
                            if (masked) begin
                                msg_addr[d]  <= nxt[d];
                                jump_pend[d] <= 1'b0;
                            end
                        end
                        st_intr: begin
                            st[d]        <= jump_pend[d] ? st_head : st_bd;
                            msg_addr[d]  <= nxt[d];
                            jump_pend[d] <= 1'b0;
                        end
                        default: st[d] <= st[d];
                    endcase
                end
            end
        end

        // set wins over a software clear in the same cycle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) done_ack[d] <= 1'b0;
            else if (done[d] && st[d] == st_ack) done_ack[d] <= 1'b1;
            else if (ack_clr[d]) done_ack[d] <= 1'b0;
        end
    end

    // serial side: pins are synchronous to pclk, so edges are found by a single delay
    logic tx_edge;
    logic rx_edge;
    logic tx_active;
    logic rx_active;
    assign tx_edge   = tx_serial_clock & ~tx_clk_q;
    assign rx_edge   = rx_serial_clock & ~rx_clk_q;
    assign tx_active = (st[0] != st_idle) & ~restart[0];
    assign rx_active = (st[1] != st_idle) & ~restart[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_clk_q      <= 1'b0;
            tx_synced     <= 1'b0;
            tx_full       <= 1'b0;
            tx_shift      <= 32'h0;
            tx_cnt        <= 5'h0;
            tx_serial_out <= 1'b1;
            tx_serial_oe  <= 1'b1;
        end else begin
            tx_clk_q     <= tx_serial_clock;
            // suspended pin floats or idles high as selected
            tx_serial_oe <= tx_active | ~ctrl[`CTRL_TRISTATE_BIT];
            if (!tx_active) begin
                tx_synced     <= 1'b0;
                tx_full       <= 1'b0;
                tx_cnt        <= 5'h0;
                tx_serial_out <= 1'b1;
            end else begin
                if (tx_frame_sync) tx_synced <= 1'b1;
                if (data_done[0]) begin
                    tx_shift <= mem_rdata;
                    tx_full  <= 1'b1;
                    tx_cnt   <= 5'h0;
                end else if (tx_edge) begin
                    if (tx_full && tx_synced) begin
                        tx_serial_out <= tx_shift[31];
                        tx_shift      <= {tx_shift[30:0], 1'b0};
                        tx_cnt        <= tx_cnt + 5'h1;
                        if (tx_cnt == `WORD_BITS) tx_full <= 1'b0;
                    end else begin
                        tx_serial_out <= 1'b1;
                    end
                end
            end
        end
    end

    // a word caught while the memory write is still pending is held, later bits dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_clk_q  <= 1'b0;
            rx_synced <= 1'b0;
            rx_full   <= 1'b0;
            rx_shift  <= 32'h0;
            rx_cnt    <= 5'h0;
        end else begin
            rx_clk_q <= rx_serial_clock;
            if (!rx_active || st[1] != st_data) begin
                rx_synced <= rx_active & (rx_synced | rx_frame_sync);
                rx_full   <= 1'b0;
                rx_cnt    <= 5'h0;
            end else begin
                if (rx_frame_sync) rx_synced <= 1'b1;
                if (data_done[1]) rx_full <= 1'b0;
                else if (rx_edge && rx_synced && !rx_out_of_frame && !rx_full) begin
                    rx_shift <= {rx_shift[30:0], rx_serial_in};
                    rx_cnt   <= rx_cnt + 5'h1;
                    if (rx_cnt == `WORD_BITS) rx_full <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ### dv/channel_sequencer_checker_assertions.sv
// apb and memory port checks for the channel descriptor sequencer
`include "channel_sequencer_map.svh"
`default_nettype none
module channel_sequencer_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic        tx_serial_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic      ctrl_tri;
    wire logic mapped;
    assign mapped = paddr inside {`SEQ_CTRL_OFS, `SEQ_HEAD_BASE_OFS, `SEQ_SLOT_BASE_OFS,
                                  `SEQ_INTQ_BASE_OFS, `SEQ_SREQ_OFS, `SEQ_STATUS_OFS};
    // shadow of the tristate select, tracked from completed writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_tri <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == `SEQ_CTRL_OFS)
            ctrl_tri <= pwdata[`CTRL_TRISTATE_BIT];
    end
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    pready_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside first access cycle");
    slverr_map_a: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address map");
    rdata_err_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read bus not quiet outside access");
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed before answer");
    mem_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request not dropped after answer");
    tx_oe_a: assert property (!ctrl_tri && !$past(ctrl_tri) && !$past(ctrl_tri, 2) |-> tx_serial_oe)
        else $error("tx pin released while hold-high selected");
endmodule
`default_nettype wire

// ### dv/shared_memory_model.sv
// shared memory with adjustable answer latency on the memory master port
`default_nettype none
module shared_memory_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] words [0:255];
    logic [3:0]  wait_cnt;
    // head pointers and lists are placed here by the host before a request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= lat) begin
            mem_ack  <= 1'b1;
            wait_cnt <= 4'h0;
            if (mem_we)
                words[mem_addr[9:2]] <= mem_wdata;
            else
                mem_rdata <= words[mem_addr[9:2]];
        end else begin
            // toggling data so a sample one cycle late sees an inverted word
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ### dv/channel_descriptor_sequencer_tb_top.sv
// directed tests of the channel descriptor sequencer against a shared memory model
`include "channel_sequencer_map.svh"
`default_nettype none
module channel_descriptor_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] tx_word = 32'ha5c3_0f01;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, mem_addr, mem_wdata, mem_rdata, cap = 0;
    logic        pready, pslverr, mem_req, mem_we, mem_ack, tx_serial_out, tx_serial_oe;
    logic        tx_serial_clock = 0, rx_serial_clock = 0, tx_frame_sync = 0, rx_frame_sync = 0;
    logic        rx_serial_in = 1, tx_run = 0, rx_run = 0, rx_first = 1, tx_seen = 0, rx_oof = 0;
    logic [31:0] rx_pat = 32'h3c96_e15a;
    logic [3:0]  lat = 0, txc_d = 0;
    logic [1:0]  sdiv = 0;
    int          fails = 0, checks_done = 0, cyc = 0;
    logic [7:0]  ix [10] = '{8'h40, 8'h41, 8'h80, 8'h81, 8'h82, 8'ha0, 8'hc0, 8'hc1, 8'hc2, 8'hc8};
    logic [31:0] vl [10] = '{32'h200, 32'h300, 32'h8000_0004, 32'h280, 32'h200, tx_word,
                             32'h4, 32'h380, 32'h320, 32'hc000_0004};
    always #50 pclk = ~pclk;
    channel_descriptor_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .tx_serial_clock(tx_serial_clock), .tx_frame_sync(tx_frame_sync),
        .tx_serial_out(tx_serial_out), .tx_serial_oe(tx_serial_oe), .rx_serial_clock(rx_serial_clock),
        .rx_frame_sync(rx_frame_sync), .rx_serial_in(rx_serial_in), .rx_out_of_frame(rx_oof));
    shared_memory_model mem (.pclk(pclk), .presetn(presetn), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // serial clocks stand still until their direction is started
    always @(posedge pclk) begin
        sdiv            <= sdiv + 2'h1;
        tx_serial_clock <= tx_run & sdiv[1];
        rx_serial_clock <= rx_run & sdiv[1];
        tx_frame_sync   <= tx_run;
        txc_d           <= {txc_d[2:0], tx_serial_clock};
        if (txc_d[2] && !txc_d[3])
            cap <= {cap[30:0], tx_serial_out};
        if (cap === tx_word)
            tx_seen <= 1'b1;
        if (rx_run && sdiv == 2'h1) begin
            rx_frame_sync <= rx_first;
            rx_oof        <= rx_first;
            rx_first      <= 1'b0;
            rx_serial_in  <= rx_first | rx_pat[31];
            if (!rx_first)
                rx_pat <= {rx_pat[30:0], rx_pat[31]};
        end
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wait_mem(input int i, input logic [31:0] e);
        int n;
        n = 0;
        while (mem.words[i] !== e && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk32(mem.words[i], e);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 256; i++)
            mem.words[i] = 32'h0;
        for (int i = 0; i < 10; i++)
            mem.words[ix[i]] = vl[i];
        repeat (4) @(posedge pclk);
        chk1(tx_serial_oe, 1'b1);
        chk1(tx_serial_out, 1'b1);
        presetn <= 1'b1;
        apb(1'b0, `SEQ_CTRL_OFS, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk1(er, 1'b1);
        apb(1'b1, `SEQ_HEAD_BASE_OFS, 32'h100);
        apb(1'b1, `SEQ_SLOT_BASE_OFS, 32'h108);
        apb(1'b1, `SEQ_INTQ_BASE_OFS, 32'h140);
        apb(1'b0, `SEQ_SLOT_BASE_OFS, 32'h0);
        chk32(rd, 32'h108);
        tx_run <= 1'b1;
        apb(1'b1, `SEQ_SREQ_OFS, 32'h1);
        wait_mem(8'h50, 32'h8000_0001);
        wait_mem(8'h42, 32'h200);
        wait_mem(8'h51, 32'h4000_0000);
        wait_mem(8'h80, 32'h4);
        for (int n = 0; n < 400 && !tx_seen; n++)
            @(posedge pclk);
        chk1(tx_seen, 1'b1);
        apb(1'b0, `SEQ_STATUS_OFS, 32'h0);
        chk1(rd[16], 1'b1);
        apb(1'b1, `SEQ_STATUS_OFS, 32'h1_0000);
        apb(1'b0, `SEQ_STATUS_OFS, 32'h0);
        chk1(rd[16], 1'b0);
        lat <= 4'h6;
        apb(1'b1, `SEQ_CTRL_OFS, 32'h2);
        apb(1'b1, `SEQ_SREQ_OFS, 32'h101);
        // second request while pending is dropped
        apb(1'b1, `SEQ_SREQ_OFS, 32'h103);
        wait_mem(8'h43, 32'h320);
        rx_run <= 1'b1;
        wait_mem(8'he0, 32'h3c96_e15a);
        wait_mem(8'h53, 32'h4000_0100);
        chk32(mem.words[8'h52], 32'h8000_0101);
        chk32(mem.words[8'hc0], 32'h4);
        apb(1'b1, `SEQ_CTRL_OFS, 32'h6);
        apb(1'b1, `SEQ_SREQ_OFS, 32'h3);
        wait_mem(8'h54, 32'h8000_0003);
        repeat (4) @(posedge pclk);
        chk1(tx_serial_oe, 1'b0);
        er = 1'b0;
        repeat (40) begin
            @(posedge pclk);
            er = er | mem_req;
        end
        chk1(er, 1'b0);
        give_verdict();
    end
endmodule
bind channel_descriptor_sequencer channel_sequencer_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .tx_serial_oe(tx_serial_oe));
`default_nettype wire
